/* File: plcr2_defines.vh */
// Constants for the second link control register block
// Assumes inclusion by plcr2_top.v only
`ifndef PLCR2_DEFINES_VH
`define PLCR2_DEFINES_VH
`define PLCR2_ADDR           5'h0a
`define PLCR2_RESET          16'h0104
`define PLCR2_RSVD_MASK      16'h3f80
`define PLCR2_B_FAREND       15
`define PLCR2_B_FX           14
`define PLCR2_B_FASTPD       6
`define PLCR2_B_EXTFD        5
`define PLCR2_B_LEDENH       4
`define PLCR2_B_ISO          3
`define PLCR2_B_IDLEERR      2
`define PLCR2_B_ODDDIS       1
`define PLCR2_B_RMIICLK      0
`define PLCR2_SPD_10         2'h0
`define PLCR2_SPD_100TX      2'h1
`define PLCR2_SPD_100FX      2'h2
`endif

/* File: plcr2_top.v */
// Second link control register of a 10/100 transceiver and the control it steers
// Assumes a management front end on SYS_CLK and link status from the PHY core
`include "plcr2_defines.vh"
module plcr2_top (
	SYS_CLK,
	RST,
	CE,
	ADDR,
	WDATA,
	WR,
	RD,
	RDATA,
	FX_STRAP,
	FAST_MDIX,
	ROBUST_MDIX,
	LINK_UP,
	SPEED,
	AN_EN,
	PARTNER_FORCED_TX,
	STD_FULL_DUPLEX,
	ACTIVITY,
	TX_EN_IN,
	TX_ER_IN,
	ODD_NIBBLE,
	TX_DISABLE,
	FX_MODE,
	FAST_PD,
	FULL_DUPLEX,
	LINK_LED,
	MII_ISOLATE,
	IDLE_ERR_EN,
	TX_EN_OUT,
	TX_ER_OUT,
	RMII_RXCLK_REF
);
	input         SYS_CLK;
	input         RST;
	input         CE;
	input  [4:0]  ADDR;
	input  [15:0] WDATA;
	input         WR;
	input         RD;
	output [15:0] RDATA;
	input         FX_STRAP;
	input         FAST_MDIX;
	input         ROBUST_MDIX;
	input         LINK_UP;
	input  [1:0]  SPEED;
	input         AN_EN;
	input         PARTNER_FORCED_TX;
	input         STD_FULL_DUPLEX;
	input         ACTIVITY;
	input         TX_EN_IN;
	input         TX_ER_IN;
	input         ODD_NIBBLE;
	output        TX_DISABLE;
	output        FX_MODE;
	output        FAST_PD;
	output        FULL_DUPLEX;
	output        LINK_LED;
	output        MII_ISOLATE;
	output        IDLE_ERR_EN;
	output        TX_EN_OUT;
	output        TX_ER_OUT;
	output        RMII_RXCLK_REF;

	reg    [15:0] RDATA;
	reg           TX_DISABLE;
	reg           FX_MODE;
	reg           FAST_PD;
	reg           FULL_DUPLEX;
	reg           LINK_LED;
	reg           MII_ISOLATE;
	reg           IDLE_ERR_EN;
	reg           TX_EN_OUT;
	reg           TX_ER_OUT;
	reg           RMII_RXCLK_REF;

	reg    [15:0] ctl_q;
	reg    [15:0] ctl_d;
	reg    [2:0]  strap_sync_q;
	reg    [1:0]  fill_q;
	reg           strap_pend_q;
	wire          strap_ok;
	reg           link_q;
	reg           stretch_q;
	reg           blink_q;
	wire          hit;
	wire          is_100;
	wire          fd_res;
	wire          ffx_link;

	assign hit = (ADDR == `PLCR2_ADDR);
	// Strap is taken only once the synchroniser holds pin samples
	assign strap_ok = strap_pend_q && (fill_q == 2'h2) &&
		(strap_sync_q[2] == strap_sync_q[1]);
	assign is_100 = (SPEED == `PLCR2_SPD_100TX) || (SPEED == `PLCR2_SPD_100FX);
	// Extended full duplex override, else standard resolution
	assign fd_res = (ctl_q[`PLCR2_B_EXTFD] && (SPEED == `PLCR2_SPD_100TX) &&
		PARTNER_FORCED_TX) ? 1'b1 : STD_FULL_DUPLEX;
	assign ffx_link = LINK_UP && (SPEED == `PLCR2_SPD_100TX) && fd_res;

	// Register next value
	always @* begin
		ctl_d = ctl_q;
		if (WR && hit) begin
			ctl_d = WDATA;
		end
		if (strap_ok) begin
			ctl_d[`PLCR2_B_FX] = strap_sync_q[1];
		end
		if (FAST_MDIX || ROBUST_MDIX) begin
			ctl_d[`PLCR2_B_FASTPD] = 1'b1;
		end
	end

	always @(posedge SYS_CLK) begin
		if (RST) begin
			ctl_q          <= `PLCR2_RESET;
			strap_sync_q   <= 3'h0;
			fill_q         <= 2'h0;
			strap_pend_q   <= 1'b1;
			link_q         <= 1'b0;
			stretch_q      <= 1'b0;
			blink_q        <= 1'b0;
			RDATA          <= 16'h0000;
			TX_DISABLE     <= 1'b0;
			FX_MODE        <= 1'b0;
			FAST_PD        <= 1'b0;
			FULL_DUPLEX    <= 1'b0;
			LINK_LED       <= 1'b0;
			MII_ISOLATE    <= 1'b0;
			IDLE_ERR_EN    <= 1'b1;
			TX_EN_OUT      <= 1'b0;
			TX_ER_OUT      <= 1'b0;
			RMII_RXCLK_REF <= 1'b0;
		end else if (CE) begin
			strap_sync_q <= {strap_sync_q[1:0], FX_STRAP};
			if (fill_q != 2'h2) begin
				fill_q <= fill_q + 2'h1;
			end
			if (strap_ok) begin
				strap_pend_q <= 1'b0;
			end
			ctl_q  <= ctl_d;
			link_q <= LINK_UP;
			RDATA  <= (RD && hit) ? ctl_q : 16'h0000;
			// Transmitter off once link is lost in 100 Mbps mode
			if (ctl_q[`PLCR2_B_FAREND] && is_100 && link_q && !LINK_UP) begin
				TX_DISABLE <= 1'b1;
			end else if (!ctl_q[`PLCR2_B_FAREND] || LINK_UP || !is_100) begin
				TX_DISABLE <= 1'b0;
			end
			FX_MODE     <= ctl_q[`PLCR2_B_FX];
			FAST_PD     <= ctl_q[`PLCR2_B_FASTPD];
			FULL_DUPLEX <= fd_res;
			blink_q     <= ACTIVITY ? ~blink_q : 1'b0;
			if (ctl_q[`PLCR2_B_LEDENH]) begin
				LINK_LED <= ffx_link;
			end else begin
				LINK_LED <= LINK_UP && !blink_q;
			end
			MII_ISOLATE <= ctl_q[`PLCR2_B_ISO] && LINK_UP &&
				((SPEED == `PLCR2_SPD_10) ||
				((SPEED == `PLCR2_SPD_100TX) && !fd_res));
			IDLE_ERR_EN <= ctl_q[`PLCR2_B_IDLEERR];
			// Odd-nibble end adds one cycle of enable carrying error
			stretch_q <= !ctl_q[`PLCR2_B_ODDDIS] && TX_EN_IN && ODD_NIBBLE;
			TX_EN_OUT <= TX_EN_IN || stretch_q;
			TX_ER_OUT <= TX_ER_IN || (stretch_q && !TX_EN_IN);
			RMII_RXCLK_REF <= ctl_q[`PLCR2_B_RMIICLK];
		end
	end
endmodule

/* File: plcr2_mac.sv */
// Transmit side of the MAC: sends a three-cycle frame ending on an odd nibble
// Assumes go is a one-cycle pulse on the shared system clock
module plcr2_mac (
	input  wire  clk,
	input  wire  go,
	output logic tx_en,
	output logic odd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] n_q = 2'h0;
	always @(posedge clk) begin
		n_q <= go ? 2'h3 : n_q - {1'b0, n_q != 2'h0};
	end
	assign tx_en = n_q != 2'h0;
	assign odd = n_q == 2'h1;
endmodule

/* File: plcr2_chk_assertions.sv */
// Checker for the second link control register, bound to plcr2_top
// Assumes CE held high and no MDIX request around a write followed by a read
module plcr2_chk (
	input wire        SYS_CLK, RST, WR, RD, FAST_MDIX, ROBUST_MDIX, TX_EN_IN, ODD_NIBBLE,
	input wire        TX_EN_OUT, FAST_PD, FX_MODE, IDLE_ERR_EN, RMII_RXCLK_REF, TX_DISABLE,
	input wire [4:0]  ADDR,
	input wire [15:0] WDATA, RDATA
);
	timeunit 1ns;
	timeprecision 1ns;
	wire wsel = WR && ADDR == 5'h0a;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	chk_reset_value: assert property ($fell(RST) |-> IDLE_ERR_EN && !TX_DISABLE)
		else $error("reset value");
	chk_read_idle: assert property (!(RD && ADDR == 5'h0a) |=> RDATA == 16'h0)
		else $error("stray read data");
	chk_write_read: assert property (wsel ##1 RD && ADDR == 5'h0a |=> RDATA == $past(WDATA, 2))
		else $error("read back");
	chk_fx_mode: assert property (wsel |-> ##2 FX_MODE == $past(WDATA[14], 2))
		else $error("optical mode");
	chk_idle_err: assert property (wsel |-> ##2 IDLE_ERR_EN == $past(WDATA[2], 2))
		else $error("idle error enable");
	chk_rmii_ref: assert property (wsel |-> ##2 RMII_RXCLK_REF == $past(WDATA[0], 2))
		else $error("receive reference");
	chk_fast_pd: assert property (FAST_MDIX || ROBUST_MDIX |-> ##2 FAST_PD)
		else $error("fast link-up not forced");
	chk_stretch_end: assert property (!TX_EN_IN && !$past(TX_EN_IN) |=> !TX_EN_OUT)
		else $error("stretch too long");
	cover property (wsel);
	cover property (TX_EN_IN && ODD_NIBBLE);
	cover property (ROBUST_MDIX);
endmodule
bind plcr2_top plcr2_chk i_chk (.*);

/* File: testbench.sv */
// Testbench for the second link control register
// Assumes plcr2_top, plcr2_mac and the bound checker are compiled first
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        SYS_CLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, FX_STRAP = 1, LINK_UP = 1;
	logic        FAST_MDIX = 0, ROBUST_MDIX = 0, AN_EN = 0, PARTNER_FORCED_TX = 1, go = 0;
	logic        STD_FULL_DUPLEX = 0, ACTIVITY = 0, TX_ER_IN = 0;
	logic [1:0]  SPEED = 2'h1;
	logic [4:0]  ADDR = 5'h0;
	logic [15:0] WDATA = 16'h0;
	wire         TX_EN_IN, ODD_NIBBLE, TX_DISABLE, FX_MODE, FAST_PD, FULL_DUPLEX, LINK_LED;
	wire         MII_ISOLATE, IDLE_ERR_EN, TX_EN_OUT, TX_ER_OUT, RMII_RXCLK_REF;
	wire [15:0]  RDATA;
	int          err_total = 0, samples_checked = 0;
	plcr2_top i_dut (.*);
	plcr2_mac i_mac (.clk(SYS_CLK), .go(go), .tx_en(TX_EN_IN), .odd(ODD_NIBBLE));
	always #50 SYS_CLK = ~SYS_CLK;
	task chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [15:0] d);
		ADDR <= 5'h0a;
		WDATA <= d;
		WR <= 1;
		@(posedge SYS_CLK);
		WR <= 0;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] e);
		ADDR <= a;
		RD <= 1;
		@(posedge SYS_CLK);
		RD <= 0;
		#1 chk(RDATA, e);
		@(posedge SYS_CLK);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge SYS_CLK);
		RST <= 0;
		repeat (8) @(posedge SYS_CLK);
		rd(5'h0a, 16'h4104);
		wr(16'hffff);
		rd(5'h0a, 16'hffff);
		chk({FX_MODE, IDLE_ERR_EN, RMII_RXCLK_REF}, 16'h7);
		wr(16'h0);
		rd(5'h0b, 16'h0);
		chk({FX_MODE, IDLE_ERR_EN, RMII_RXCLK_REF}, 16'h0);
		for (int i = 0; i < 2; i++) begin
			{ROBUST_MDIX, FAST_MDIX} <= 2'h1 << i;
			repeat (3) @(posedge SYS_CLK);
			rd(5'h0a, 16'h0040);
			chk(FAST_PD, 16'h1);
			{ROBUST_MDIX, FAST_MDIX} <= 2'h0;
			wr(16'h0);
		end
		$display("register tests done");
		for (int i = 0; i < 2; i++) begin
			wr(16'(i * 2));
			go <= 1;
			@(posedge SYS_CLK);
			go <= 0;
			repeat (4) @(posedge SYS_CLK);
			#1 chk({TX_EN_OUT, TX_ER_OUT}, i ? 16'h0 : 16'h3);
			@(posedge SYS_CLK);
		end
		wr(16'h8000);
		{LINK_UP, FX_STRAP, PARTNER_FORCED_TX} <= 3'h0;
		repeat (3) @(posedge SYS_CLK);
		#1 chk(TX_DISABLE, 16'h1);
		@(posedge SYS_CLK);
		wr(16'h0038);
		{LINK_UP, PARTNER_FORCED_TX} <= 2'h3;
		repeat (3) @(posedge SYS_CLK);
		#1 chk({FULL_DUPLEX, LINK_LED, MII_ISOLATE}, 16'h6);
		@(posedge SYS_CLK);
		PARTNER_FORCED_TX <= 0;
		repeat (3) @(posedge SYS_CLK);
		#1 chk({FULL_DUPLEX, LINK_LED, MII_ISOLATE}, 16'h1);
		@(posedge SYS_CLK);
		wr(16'h0);
		repeat (3) @(posedge SYS_CLK);
		#1 chk({FULL_DUPLEX, LINK_LED, MII_ISOLATE}, 16'h2);
		$display("link tests done");
		end_of_test();
	end
endmodule
